// >>> design/vsr_pkg.sv
// Constants, enumerations and carrier types for the video sync to stream receiver
// What this block does
// - Drop blanking except ancillary packets, forward active picture
// - Pass active samples unchanged, same plane layout
// - Accept 8/10-bit sync words, ignore two LSBs
// - Horizontal blanking flag from sync word
// - Vertical blanking flag from sync word
// - Field flag from sync word
// - Never inspect unused sync word bits
// - Embedded mode reads data only when valid
// - Ancillary packets from luma in vertical blanking
// - Separate mode: every valid sample is active
// - Build control and video packets per field
// - Carry video into the system clock domain
// - Ignore video inputs while lock is low
// - Lock loss ends the current frame early
// - Output disabled after reset, detection continues
// - Go bit starts output at matching field start
// - Clearing go stops at matching field end
// - Interlaced output in whole field pairs
// - Progressive: F1-first gives nothing, else F0s
// - Status interrupt on format change or disconnect
// - Two interrupts, enables and W1C bits [2:1]
// - Stable when two of three lines match
package vsr_pkg;
	// Bits per colour sample and planes per beat
	localparam int BPS = 10;
	localparam int PLANES = 2;
	localparam int VID_DW = BPS * PLANES;
	// Register word offsets
	localparam logic [2:0] ADDR_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h1;
	localparam logic [2:0] ADDR_INTERRUPT = 3'h2;
	localparam logic [2:0] ADDR_WIDTH = 3'h3;
	localparam logic [2:0] ADDR_HEIGHT = 3'h4;
	// Field positions
	localparam int CTRL_GO = 0;
	localparam int STAT_OUT = 0;
	localparam int STAT_STABLE = 1;
	localparam int STAT_INTERLACED = 2;
	localparam int STAT_OVERFLOW = 3;
	localparam int INT_UPD = 1;
	localparam int INT_STB = 2;
	// Reset values
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [15:0] SIZE_RESET = 16'h0000;
	// Packet types in the header beat
	localparam logic [3:0] PKT_VIDEO = 4'h0;
	localparam logic [3:0] PKT_ANC = 4'hd;
	localparam logic [3:0] PKT_CTRL = 4'hf;
	// Timing reference words, top eight bits
	localparam logic [7:0] TRS_ONES = 8'hff;
	localparam logic [7:0] TRS_ZERO = 8'h00;
	// Flag positions in the top eight bits of a sync word
	localparam int XYZ_H = 4;
	localparam int XYZ_V = 5;
	localparam int XYZ_F = 6;
	// Control packet: header plus five nibble-pair beats
	localparam logic [2:0] CTRL_LAST = 3'h5;
	// Ancillary words before the data count arrives
	localparam logic [1:0] ANC_DC_IDX = 2'h2;
	localparam logic [1:0] ANC_DATA_IDX = 2'h3;
	// Field order choices
	typedef enum logic [1:0] {
		ORDER_F1_FIRST = 2'h0,
		ORDER_F0_FIRST = 2'h1,
		ORDER_ANY = 2'h2
	} vsr_order_type;
	// Output sequencer states, Gray along idle-ctrl-video
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CTRL = 2'b01,
		ST_VIDEO = 2'b11,
		ST_ANC = 2'b10
	} vsr_state_type;
	// Video pins as one bundle through the synchroniser
	typedef struct packed {
		logic vclk;
		logic locked;
		logic dv;
		logic h;
		logic v;
		logic f;
		logic [VID_DW-1:0] data;
	} vsr_vid_type;
	// One stream beat
	typedef struct packed {
		logic sop;
		logic eop;
		logic [VID_DW-1:0] data;
	} vsr_beat_type;
endpackage : vsr_pkg

// >>> design/vsr_video_rx.sv
// Clocked video to flow-controlled packet stream receiver with register port
`timescale 1ns/10ps
`default_nettype none
module vsr_video_rx
	import vsr_pkg::*;
#(
	parameter bit EMBEDDED = 1'b1,
	parameter bit TEN_BIT = 1'b1,
	parameter vsr_order_type FIELD_ORDER = ORDER_ANY
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] av_address,
	input wire logic av_read,
	input wire logic av_write,
	input wire logic [31:0] av_writedata,
	output logic [31:0] av_readdata,
	output logic av_waitrequest,
	input wire logic vid_clk,
	input wire logic [VID_DW-1:0] vid_data,
	input wire logic vid_datavalid,
	input wire logic vid_locked,
	input wire logic vid_h_sync,
	input wire logic vid_v_sync,
	input wire logic vid_f,
	output logic [VID_DW-1:0] dout_data,
	output logic dout_valid,
	output logic dout_startofpacket,
	output logic dout_endofpacket,
	input wire logic dout_ready,
	output logic status_irq
);

	// Top eight bits of the luma word; two LSBs dropped in 10-bit mode
	function automatic logic [7:0] sync_top(input logic [BPS-1:0] w);
		sync_top = TEN_BIT ? w[BPS-1:BPS-8] : w[7:0];
	endfunction : sync_top

	// Data of one control packet beat, nibbles in the low bits of each plane
	function automatic logic [VID_DW-1:0] ctrl_data(input logic [2:0] idx,
		input logic [15:0] w, input logic [15:0] h, input logic [3:0] il);
		logic [3:0] n0;
		logic [3:0] n1;
		n0 = 4'h0;
		n1 = 4'h0;
		case (idx)
			3'h0: n0 = PKT_CTRL;
			3'h1: begin n0 = w[15:12]; n1 = w[11:8]; end
			3'h2: begin n0 = w[7:4]; n1 = w[3:0]; end
			3'h3: begin n0 = h[15:12]; n1 = h[11:8]; end
			3'h4: begin n0 = h[7:4]; n1 = h[3:0]; end
			default: n0 = il;
		endcase
		ctrl_data = '0;
		ctrl_data[3:0] = n0;
		ctrl_data[BPS+3:BPS] = n1;
	endfunction : ctrl_data

	////////////////////////////////////////////////////////////////////////////
	// Input synchroniser and video clock edge detection
	vsr_vid_type vin; // Raw pin bundle
	vsr_vid_type sync1; // First stage, read only by sync2
	vsr_vid_type sync2; // Second stage, safe to use
	logic vclk_d; // Previous video clock level
	logic lock_d; // Previous lock level
	logic vtick; // One sample slot of the video clock
	logic lock_fall; // Lock just dropped

	assign vin = {vid_clk, vid_locked, vid_datavalid, vid_h_sync, vid_v_sync, vid_f, vid_data};

	// Two flip-flops before any logic looks at the pins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1 <= '0;
			sync2 <= '0;
			vclk_d <= 1'b0;
			lock_d <= 1'b0;
		end else begin
			sync1 <= vin;
			sync2 <= sync1;
			vclk_d <= sync2.vclk;
			lock_d <= sync2.locked;
		end
	end

	// Act on the falling video clock edge, mid-way through stable data
	assign vtick = vclk_d & ~sync2.vclk & sync2.locked;
	assign lock_fall = lock_d & ~sync2.locked;

	////////////////////////////////////////////////////////////////////////////
	// Timing decode
	logic [7:0] top; // Sync view of current luma word
	logic [7:0] w1; // Last valid word
	logic [7:0] w2; // Word before that
	logic [7:0] w3; // Oldest of three
	logic sample; // A data word is read this slot
	logic trs_hit; // Current word is a sync word
	logic pre_hit; // Current word is part of a timing preamble
	logic flag_upd; // Flags refresh this slot
	logic h_flag; // Horizontal blanking
	logic v_flag; // Vertical blanking
	logic f_flag; // Field 1
	logic next_h;
	logic next_v;
	logic next_f;
	logic active_word; // Active picture word
	logic anc_word; // Luma word inside vertical blanking
	logic adf_hit; // Ancillary data flag completed
	logic fs; // Field start
	logic fe; // Field end
	logic line_end; // Horizontal blanking begins

	assign top = sync_top(sync2.data[BPS-1:0]);
	assign sample = vtick & sync2.dv;
	assign trs_hit = EMBEDDED & (w3 == TRS_ONES) & (w2 == TRS_ZERO) & (w1 == TRS_ZERO);
	assign pre_hit = (top == TRS_ONES) | ((top == TRS_ZERO) & (w1 == TRS_ONES))
		| ((top == TRS_ZERO) & (w1 == TRS_ZERO) & (w2 == TRS_ONES));
	assign flag_upd = EMBEDDED ? (sample & trs_hit) : vtick;

	// Only bits H, V and F of the sync word are looked at
	always_comb begin
		next_h = h_flag;
		next_v = v_flag;
		next_f = f_flag;
		if (flag_upd) begin
			if (EMBEDDED) begin
				next_h = top[XYZ_H];
				next_v = top[XYZ_V];
				next_f = top[XYZ_F];
			end else begin
				next_h = sync2.h;
				next_v = sync2.v;
				next_f = sync2.f;
			end
		end
	end

	// Active words: embedded drops blanking, separate takes every valid word
	assign active_word = EMBEDDED
		? (sample & ~trs_hit & ~pre_hit & ~next_h & ~next_v)
		: sample;
	assign anc_word = EMBEDDED & sample & ~trs_hit & ~pre_hit & next_v & ~next_h;
	// Flag words 00, ff, ff: the ones also start a preamble, so pre_hit must not veto them
	assign adf_hit = EMBEDDED & sample & ~trs_hit & next_v & ~next_h & (w2 == TRS_ZERO)
		& (w1 == TRS_ONES) & (top == TRS_ONES);
	assign fs = flag_upd & v_flag & ~next_v;
	assign fe = flag_upd & ~v_flag & next_v;
	assign line_end = flag_upd & ~h_flag & next_h;

	// Word history and flag registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			w1 <= 8'h00;
			w2 <= 8'h00;
			w3 <= 8'h00;
			h_flag <= 1'b1;
			v_flag <= 1'b1;
			f_flag <= 1'b0;
		end else if (lock_fall) begin
			// Back to blanking so relock cannot fake a field end
			h_flag <= 1'b1;
			v_flag <= 1'b1;
		end else begin
			if (sample) begin
				w1 <= top;
				w2 <= w1;
				w3 <= w2;
			end
			h_flag <= next_h;
			v_flag <= next_v;
			f_flag <= next_f;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Format detection, stability and interrupts
	logic [15:0] line_act; // Active words in current line
	logic [15:0] line_tot; // All words in current line
	logic [15:0] tot1; // Total of last line
	logic [15:0] tot2; // Total of line before
	logic [15:0] act_lines; // Active lines in current field
	logic [15:0] width; // Detected active width
	logic [15:0] height; // Detected active height
	logic [15:0] lines_done; // Active lines, counting one that ends this cycle
	logic stable; // Two of three lines agree
	logic next_stable;
	logic interlaced; // Field 1 seen recently
	logic fmt_change; // Width or height moved
	logic [2:1] ints; // Sticky interrupt bits
	logic [2:0] ctrl; // Control register
	logic wr_acc; // Accepted write
	logic prev_f; // Field flag of last ended field

	// Field end and the last line end share one sync word, so add that line here
	assign lines_done = act_lines + {15'h0000, line_end & (line_act != 16'h0000)};
	assign fmt_change = (line_end & (line_act != 16'h0000) & (line_act != width))
		| (fe & (lines_done != height));

	// Stable when any two of this line total and the last two agree
	always_comb begin
		next_stable = stable;
		if (!sync2.locked)
			next_stable = 1'b0;
		else if (line_end)
			next_stable = (line_tot == tot1) | (line_tot == tot2) | (tot1 == tot2);
	end

	// Line and field counters, detected size
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			line_act <= 16'h0000;
			line_tot <= 16'h0000;
			tot1 <= 16'h0000;
			tot2 <= 16'h0000;
			act_lines <= 16'h0000;
			width <= SIZE_RESET;
			height <= SIZE_RESET;
			stable <= 1'b0;
			interlaced <= 1'b0;
		end else begin
			stable <= next_stable;
			if (line_end) begin
				line_tot <= 16'h0000;
				line_act <= 16'h0000;
				tot1 <= line_tot;
				tot2 <= tot1;
				if (line_act != 16'h0000) begin
					width <= line_act;
					act_lines <= act_lines + 16'h0001;
				end
			end else if (sample) begin
				line_tot <= line_tot + 16'h0001;
				if (active_word)
					line_act <= line_act + 16'h0001;
			end
			if (fe) begin
				height <= lines_done;
				act_lines <= 16'h0000;
				if (f_flag)
					interlaced <= 1'b1;
				else if (!prev_f)
					interlaced <= 1'b0;
			end
		end
	end

	// Sticky interrupts; a set in the clearing cycle wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ints <= 2'b00;
		end else begin
			if (wr_acc && av_address == ADDR_INTERRUPT)
				ints <= ints & ~av_writedata[2:1];
			if (fmt_change || lock_fall)
				ints[INT_UPD] <= 1'b1;
			if (next_stable != stable)
				ints[INT_STB] <= 1'b1;
		end
	end

	assign status_irq = |(ints & ctrl[2:1]);

	// Label a_stable_irq guards interrupt cause
	a_stable_irq: assert property (@(posedge clk) disable iff (reset)
		$rose(ints[INT_STB]) |-> (stable != $past(stable)))
		else $error("stable interrupt without stability change");
	a_lock_unstable: assert property (@(posedge clk) disable iff (reset)
		!sync2.locked |=> !stable)
		else $error("stable reported while unlocked");
	a_disc_irq: assert property (@(posedge clk) disable iff (reset)
		lock_fall |=> ints[INT_UPD])
		else $error("disconnect did not raise status interrupt");

	////////////////////////////////////////////////////////////////////////////
	// Output enable on field boundaries
	logic out_on; // Output running, status bit 0
	logic in_frame; // Current field is being sent
	logic start_f; // Field output started on
	logic start_ok; // Field matches order setting
	logic start_now; // This field start is sent
	logic pair_done; // Field end closes a whole pair

	always_comb begin
		case (FIELD_ORDER)
			ORDER_F1_FIRST: start_ok = next_f;
			ORDER_F0_FIRST: start_ok = ~next_f;
			default: start_ok = 1'b1;
		endcase
	end

	assign start_now = fs & (out_on | (ctrl[CTRL_GO] & start_ok));
	// Pair ends on the other field, or on a repeat field when progressive
	assign pair_done = (f_flag != start_f) | (f_flag == prev_f);

	// Start, stop and field tracking
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			out_on <= 1'b0;
			in_frame <= 1'b0;
			start_f <= 1'b0;
			prev_f <= 1'b1;
		end else begin
			if (fs) begin
				in_frame <= start_now;
				if (!out_on && start_now) begin
					out_on <= 1'b1;
					start_f <= next_f;
				end
			end else if (fe) begin
				in_frame <= 1'b0;
				prev_f <= f_flag;
				if (out_on && !ctrl[CTRL_GO] && pair_done)
					out_on <= 1'b0;
			end else if (lock_fall) begin
				in_frame <= 1'b0;
			end
		end
	end

	a_start_field: assert property (@(posedge clk) disable iff (reset)
		$rose(out_on) |-> ($past(fs) && $past(ctrl[CTRL_GO])))
		else $error("output started off a field start or without go");
	a_stop_field: assert property (@(posedge clk) disable iff (reset)
		$fell(out_on) |-> ($past(fe) && !$past(ctrl[CTRL_GO])))
		else $error("output stopped off a field end or with go set");
	a_order_f1: assert property (@(posedge clk) disable iff (reset)
		($rose(out_on) && FIELD_ORDER == ORDER_F1_FIRST) |-> start_f)
		else $error("field 1 first started on field 0");

	////////////////////////////////////////////////////////////////////////////
	// Packet sequencer and output beat
	vsr_state_type state; // Packet context
	logic [2:0] cidx; // Control beat index
	logic [1:0] anc_idx; // Ancillary word index, saturating
	logic [8:0] anc_left; // Ancillary words still due
	logic anc_last; // Last ancillary word this slot
	vsr_beat_type pend; // Beat held back so the last can carry end
	logic pend_valid;
	logic flush_req; // Pending beat must go out with end flag
	vsr_beat_type ob; // Output beat register
	logic slot_free; // Output register can take a beat
	logic take; // A word for the open packet arrives
	logic blocked; // It cannot be taken
	logic push_word; // Held beat leaves, new word held
	logic push_en;
	logic push_flush;
	vsr_beat_type push_beat;
	logic overflow; // Sticky lost-word flag

	assign slot_free = ~dout_valid | dout_ready;
	assign take = (in_frame & active_word) | ((state == ST_ANC) & anc_word & ~adf_hit);
	assign blocked = take & ((state == ST_CTRL) | ~slot_free);
	assign push_word = take & ~blocked;
	assign anc_last = (state == ST_ANC) & push_word & (anc_idx == ANC_DATA_IDX)
		& (anc_left == 9'h001);

	// Choose the beat for the output register
	always_comb begin
		push_en = 1'b0;
		push_flush = 1'b0;
		push_beat = pend;
		if (push_word) begin
			push_en = 1'b1;
		end else if (state == ST_CTRL) begin
			push_en = slot_free;
			push_beat.sop = (cidx == 3'h0);
			push_beat.eop = (cidx == CTRL_LAST);
			push_beat.data = ctrl_data(cidx, width, height, {interlaced, f_flag, 2'b00});
		end else if (flush_req && pend_valid) begin
			push_en = slot_free;
			push_flush = slot_free;
			push_beat.eop = 1'b1;
		end
	end

	// Sequencer state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
			cidx <= 3'h0;
			anc_idx <= 2'h0;
			anc_left <= 9'h000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_now) begin
						state <= ST_CTRL;
						cidx <= 3'h0;
					end else if (adf_hit && out_on) begin
						state <= ST_ANC;
						anc_idx <= 2'h0;
					end
				end
				ST_CTRL: begin
					if (push_en) begin
						cidx <= cidx + 3'h1;
						if (cidx == CTRL_LAST)
							state <= ST_VIDEO;
					end
				end
				ST_VIDEO: begin
					if (fe || lock_fall)
						state <= ST_IDLE;
				end
				ST_ANC: begin
					if (anc_last || lock_fall || fs) begin
						state <= ST_IDLE;
					end else if (push_word) begin
						if (anc_idx == ANC_DC_IDX)
							anc_left <= {1'b0, sync2.data[7:0]} + 9'h001;
						else if (anc_idx == ANC_DATA_IDX)
							anc_left <= anc_left - 9'h001;
						if (anc_idx != ANC_DATA_IDX)
							anc_idx <= anc_idx + 2'h1;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Held beat and flush request; a new end wins over a finished flush
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pend <= '0;
			pend_valid <= 1'b0;
			flush_req <= 1'b0;
		end else begin
			if (push_flush) begin
				pend_valid <= 1'b0;
				flush_req <= 1'b0;
			end
			if (start_now) begin
				pend <= '{sop: 1'b1, eop: 1'b0, data: VID_DW'(PKT_VIDEO)};
				pend_valid <= 1'b1;
			end else if (state == ST_IDLE && adf_hit && out_on) begin
				pend <= '{sop: 1'b1, eop: 1'b0, data: VID_DW'(PKT_ANC)};
				pend_valid <= 1'b1;
			end else if (push_word) begin
				pend <= '{sop: 1'b0, eop: 1'b0, data: sync2.data};
			end
			if (((fe || lock_fall) && in_frame) || anc_last
				|| ((lock_fall || fs) && state == ST_ANC))
				flush_req <= 1'b1;
		end
	end

	// Output register holds until the sink takes it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ob <= '0;
			dout_valid <= 1'b0;
		end else if (push_en) begin
			ob <= push_beat;
			dout_valid <= 1'b1;
		end else if (dout_ready) begin
			dout_valid <= 1'b0;
		end
	end

	assign dout_data = ob.data;
	assign dout_startofpacket = ob.sop;
	assign dout_endofpacket = ob.eop;

	a_beat_hold: assert property (@(posedge clk) disable iff (reset)
		(dout_valid && !dout_ready) |=> (dout_valid && $stable(dout_data)
		&& $stable(dout_startofpacket) && $stable(dout_endofpacket)))
		else $error("output beat changed while stalled");
	a_lock_end: assert property (@(posedge clk) disable iff (reset)
		(lock_fall && in_frame && !fs && !fe) |=> (!in_frame && flush_req))
		else $error("lock loss did not end the frame");
	a_blank_drop: assert property (@(posedge clk) disable iff (reset)
		(push_word && state == ST_VIDEO) |-> (active_word && sync2.locked))
		else $error("blanking word forwarded as picture");

	////////////////////////////////////////////////////////////////////////////
	// Register port: one wait cycle, then the answer
	logic ack; // Second cycle of an access

	assign av_waitrequest = (av_read | av_write) & ~ack;
	assign wr_acc = av_write & ack;

	// Access handshake and read data
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack <= 1'b0;
			av_readdata <= 32'h0000_0000;
		end else begin
			ack <= (av_read | av_write) & ~ack;
			if (av_read && !ack) begin
				case (av_address)
					ADDR_CONTROL: av_readdata <= {29'h0, ctrl};
					ADDR_STATUS: av_readdata <= {28'h0, overflow, interlaced, stable, out_on};
					ADDR_INTERRUPT: av_readdata <= {29'h0, ints, 1'b0};
					ADDR_WIDTH: av_readdata <= {16'h0, width};
					ADDR_HEIGHT: av_readdata <= {16'h0, height};
					default: av_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control register and sticky overflow; a loss in the clear cycle wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl <= CTRL_RESET;
			overflow <= 1'b0;
		end else begin
			if (wr_acc && av_address == ADDR_CONTROL)
				ctrl <= av_writedata[2:0];
			if (wr_acc && av_address == ADDR_STATUS && av_writedata[STAT_OVERFLOW])
				overflow <= 1'b0;
			if (blocked)
				overflow <= 1'b1;
		end
	end

	a_wait_one: assert property (@(posedge clk) disable iff (reset)
		((av_read || av_write) && av_waitrequest) |=> !av_waitrequest)
		else $error("register access not answered in one wait cycle");

endmodule : vsr_video_rx
`default_nettype wire

// >>> bench/vsr_src.sv
// Embedded-sync 10-bit video source model for the receiver's video pins
`timescale 1ns/10ps
`default_nettype none
module vsr_src
	import vsr_pkg::*;
(
	output logic vid_clk,
	output logic [VID_DW-1:0] vid_data,
	output logic vid_datavalid,
	output logic vid_locked
);
	// Free-running pixel clock of 400 ns, idle pins at time zero
	initial begin
		vid_clk = 1'b0;
		vid_data = '0;
		vid_datavalid = 1'b0;
		vid_locked = 1'b1;
		forever #200 vid_clk = ~vid_clk;
	end
	// One word, launched on a rising pixel clock edge
	task automatic put(input logic [VID_DW-1:0] d, input logic dv);
		@(posedge vid_clk);
		vid_data <= d;
		vid_datavalid <= dv;
	endtask : put
	// Reference preamble, then a sync word with junk in its unused bits
	task automatic trs(input logic f, input logic v, input logic h);
		put(20'h003ff, 1'b1);
		put(20'h00000, 1'b1);
		put(20'h00000, 1'b1);
		put({10'h200, ~h, f, v, h, 6'h15}, 1'b1);
	endtask : trs
	// Ancillary packet in luma: flag, ids, count of two, two user words, checksum
	task automatic anc();
		put(20'h00000, 1'b1);
		put(20'h003ff, 1'b1);
		put(20'h003ff, 1'b1);
		for (int i = 0; i < 6; i++) begin
			put((i == 2) ? 20'h00002 : 20'h00041 + 20'(i), 1'b1);
		end
	endtask : anc
	// One line; each sample is followed by a look-alike word marked invalid
	task automatic line(input logic f, input logic v, input int n);
		trs(f, v, 1'b1);
		put(20'h20040, 1'b1);
		trs(f, v, 1'b0);
		for (int i = 0; i < n; i++) begin
			put({10'h155, 10'h080 + 10'(i)}, 1'b1);
			put(20'h003ff, 1'b0);
		end
	endtask : line
	// One field: blanking, n active lines, blanking
	task automatic field(input logic f, input int n);
		line(f, 1'b1, 2);
		for (int l = 0; l < n; l++) begin
			line(f, 1'b0, 4);
		end
		line(f, 1'b1, 2);
		line(f, 1'b1, 2);
	endtask : field
	// Lock indication change
	task automatic lock(input logic l);
		@(posedge vid_clk);
		vid_locked <= l;
	endtask : lock
endmodule : vsr_src
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the video receiver
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import vsr_pkg::*;
;
	logic clk, reset, av_read, av_write, av_waitrequest, dout_valid, sop, eop, status_irq;
	logic vclk, vdv, vlock, ready, stall, vhs, vvs, vfld;
	logic [2:0] av_address;
	logic [31:0] av_writedata, av_readdata, r;
	logic [VID_DW-1:0] vdata, dout_data;
	vsr_beat_type q[$];
	int errors = 0;
	int check_count = 0;
	vsr_src src (.vid_clk(vclk), .vid_data(vdata), .vid_datavalid(vdv), .vid_locked(vlock));
	vsr_video_rx #(.EMBEDDED(1'b1), .TEN_BIT(1'b1), .FIELD_ORDER(ORDER_ANY)) i_dut (
		.clk(clk), .reset(reset), .av_address(av_address), .av_read(av_read),
		.av_write(av_write), .av_writedata(av_writedata), .av_readdata(av_readdata),
		.av_waitrequest(av_waitrequest), .vid_clk(vclk), .vid_data(vdata),
		.vid_datavalid(vdv), .vid_locked(vlock), .vid_h_sync(vhs), .vid_v_sync(vvs),
		.vid_f(vfld), .dout_data(dout_data), .dout_valid(dout_valid),
		.dout_startofpacket(sop), .dout_endofpacket(eop), .dout_ready(ready),
		.status_irq(status_irq));
	// 50 ns system clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Collect every beat that leaves the stream port
	always @(posedge clk) begin
		if (dout_valid === 1'b1 && ready === 1'b1) begin
			q.push_back({sop, eop, dout_data});
		end
	end
	// Sink ready toggles every cycle while stall is set
	always @(posedge clk) begin
		ready <= stall ? ~ready : 1'b1;
	end
	task automatic close_out();
		if (errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// One register access, held until waitrequest is seen low
	task automatic acc(input logic wr, input logic [2:0] a, input logic [31:0] wd);
		av_address <= a;
		av_write <= wr;
		av_read <= ~wr;
		av_writedata <= wd;
		do begin
			@(posedge clk);
		end while (av_waitrequest !== 1'b0);
		r = av_readdata;
		av_read <= 1'b0;
		av_write <= 1'b0;
		@(posedge clk);
	endtask : acc
	task automatic rdck(input logic [2:0] a, input logic [31:0] m, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(r & m, e);
	endtask : rdck
	// Whole field: control packet, video header, samples, end flag on the last
	task automatic chk_field(input int n);
		repeat (20) @(posedge clk);
		chk(32'(q.size()), (n > 0) ? 32'(7 + 4 * n) : 32'h0);
		if (n > 0 && q.size() == 7 + 4 * n) begin
			chk(32'({q[0].sop, q[0].data[3:0]}), {27'h0, 1'b1, PKT_CTRL});
			chk(32'(q[2]), 32'h1000);
			chk(32'(q[6]), 32'h200000);
			for (int i = 0; i < 4 * n; i++) begin
				chk(32'(q[7 + i]), {11'h0, i == 4 * n - 1, 10'h155, 10'h080 + 10'(i % 4)});
			end
		end
		q.delete();
	endtask : chk_field
	// Watchdog
	initial begin
		#3000000;
		errors++;
		close_out();
	end
	initial begin
		reset = 1'b1;
		{av_read, av_write, av_address, av_writedata} = '0;
		{ready, stall} = 2'b10;
		{vhs, vvs, vfld} = 3'b010;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rdck(ADDR_CONTROL, 32'h7, 32'h0);
		rdck(ADDR_STATUS, 32'h1, 32'h0);
		rdck(3'h5, 32'hffffffff, 32'h0);
		src.field(1'b0, 2);
		chk_field(0);
		rdck(ADDR_WIDTH, 32'hffff, 32'h4);
		rdck(ADDR_HEIGHT, 32'hffff, 32'h2);
		acc(1'b1, ADDR_CONTROL, 32'h7);
		src.field(1'b0, 2);
		chk_field(2);
		rdck(ADDR_STATUS, 32'h1, 32'h1);
		src.trs(1'b0, 1'b1, 1'b0);
		src.anc();
		repeat (20) @(posedge clk);
		chk(32'(q.size()), 32'h7);
		if (q.size() == 7) begin
			chk(32'(q[0]), 32'h20000d);
			chk(32'(q[6]), 32'h100046);
		end
		q.delete();
		stall <= 1'b1;
		{vhs, vvs, vfld} <= 3'b101;
		src.field(1'b0, 3);
		stall <= 1'b0;
		chk_field(3);
		rdck(ADDR_STATUS, 32'h8, 32'h0);
		acc(1'b1, ADDR_CONTROL, 32'h6);
		src.field(1'b0, 2);
		chk_field(2);
		rdck(ADDR_STATUS, 32'h1, 32'h0);
		src.field(1'b0, 2);
		chk_field(0);
		acc(1'b1, ADDR_CONTROL, 32'h7);
		src.field(1'b0, 2);
		chk_field(2);
		acc(1'b1, ADDR_INTERRUPT, 32'h6);
		rdck(ADDR_INTERRUPT, 32'h2, 32'h0);
		src.line(1'b0, 1'b1, 2);
		src.line(1'b0, 1'b0, 4);
		src.lock(1'b0);
		repeat (30) @(posedge clk);
		chk(32'(q.size()), 32'd11);
		if (q.size() == 11) chk(32'(q[10].eop), 32'h1);
		q.delete();
		rdck(ADDR_INTERRUPT, 32'h2, 32'h2);
		chk(32'(status_irq), 32'h1);
		acc(1'b1, ADDR_INTERRUPT, 32'h6);
		rdck(ADDR_INTERRUPT, 32'h6, 32'h0);
		chk(32'(status_irq), 32'h0);
		src.lock(1'b1);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
